// ===== hw/flash_adc_pipeline.v
// clocked output pipeline of a 7-bit flash converter
//
// Operation
// - The converter clock high is auto-zero and clock low is sampling, and only it sequences work.
// - While sampling, comparator decisions are latched and encoded to a 7-bit result.
// - On the converter clock rising, the encoder result loads into the output latch.
// - In continuous running one new result appears per converter clock cycle.
// - Data is straight binary: 00 at zero, 40 at half scale, 7F at full scale, overflow clear.
// - At the overflow level the overflow bit sets and all data bits stay one (FF).
// - Data bits drive only when data select low is 0 and output select is 1; overflow when output select is 1.
`timescale 1ns/1ns
`include "flash_adc_regs.vh"
module flash_adc_pipeline #(
  parameter LEVELS = `ADC_LEVELS,
  parameter BITS   = `ADC_DATA_BITS
) (
  // system
  input  wire              clk_sys,
  input  wire              srst,
  // converter clock and comparator bank, both from pins
  input  wire              conv_clk,
  input  wire [LEVELS-1:0] comparators,
  // output enables, from pins
  input  wire              data_select_active_low,
  input  wire              output_select_active_high,
  // three-state outputs
  output reg  [BITS-1:0]   data_out,
  output reg  [BITS-1:0]   data_oe,
  output reg               overflow_out,
  output reg               overflow_oe,
  // one-cycle pulse one cycle before a new result is presented
  output reg               result_strobe
);
  localparam ST_AUTOZERO = 2'b01;
  localparam ST_SAMPLE   = 2'b10;

  // two-stage synchronisers
  reg              clk_s1_reg, clk_s2_reg;
  reg [LEVELS-1:0] cmp_s1_reg, cmp_s2_reg;
  reg              dsel_s1_reg, dsel_s2_reg;
  reg              osel_s1_reg, osel_s2_reg;
  reg [1:0]        state_reg;
  reg [1:0]        state_next;
  reg [LEVELS-1:0] latch_reg;
  reg [BITS:0]     result_reg;
  wire [BITS:0]    enc_code;
  wire             sampling;
  wire             rising;

  always @(posedge clk_sys) begin
    clk_s1_reg  <= conv_clk;
    clk_s2_reg  <= clk_s1_reg;
    cmp_s1_reg  <= comparators;
    cmp_s2_reg  <= cmp_s1_reg;
    dsel_s1_reg <= data_select_active_low;
    dsel_s2_reg <= dsel_s1_reg;
    osel_s1_reg <= output_select_active_high;
    osel_s2_reg <= osel_s1_reg;
  end

  assign sampling = (state_reg == ST_SAMPLE);
  assign rising   = sampling && clk_s2_reg;

  // phase follows the converter clock level alone
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_AUTOZERO: if (!clk_s2_reg) state_next = ST_SAMPLE;
      ST_SAMPLE:   if (clk_s2_reg)  state_next = ST_AUTOZERO;
      default:     state_next = ST_AUTOZERO;
    endcase
  end

  // latches are transparent while sampling, frozen in auto-zero
  always @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= ST_AUTOZERO;
      latch_reg <= {LEVELS{1'b0}};
    end else begin
      state_reg <= state_next;
      if (sampling && !clk_s2_reg) begin
        latch_reg <= cmp_s2_reg;
      end
    end
  end

  // encoder also tracks during sampling so its code is ready at the rise
  thermo_encoder #(
    .LEVELS (LEVELS),
    .BITS   (BITS)
  ) u_enc (
    .clk_sys  (clk_sys),
    .load     (sampling),
    .thermo   (latch_reg),
    .code_reg (enc_code)
  );

  // output latch; every rising edge gives one new pipelined result
  // a full count of LEVELS means overflow; data bits then stay all ones
  always @(posedge clk_sys) begin
    if (srst) begin
      result_reg    <= `ADC_RESULT_RESET;
      result_strobe <= 1'b0;
    end else begin
      result_strobe <= rising;
      if (rising) begin
        // straight binary, overflow keeps data high
        result_reg <= enc_code[BITS] ? {1'b1, {BITS{1'b1}}} : {1'b0, enc_code[BITS-1:0]};
      end
    end
  end

  // three-state control, registered to keep outputs glitch free
  always @(posedge clk_sys) begin
    if (srst) begin
      data_out     <= {BITS{1'b0}};
      data_oe      <= {BITS{1'b0}};
      overflow_out <= 1'b0;
      overflow_oe  <= 1'b0;
    end else begin
      data_out     <= result_reg[BITS-1:0];
      overflow_out <= result_reg[BITS];
      data_oe      <= {BITS{~dsel_s2_reg & osel_s2_reg}};
      overflow_oe  <= osel_s2_reg;
    end
  end
endmodule

// ===== common/flash_adc_regs.vh
// constants for the flash converter output pipeline
`ifndef FLASH_ADC_REGS_VH
`define FLASH_ADC_REGS_VH

`define ADC_DATA_BITS      7
`define ADC_LEVELS         128
`define ADC_CODE_ZERO      7'h00
`define ADC_CODE_HALF      7'h40
`define ADC_CODE_FULL      7'h7F
`define ADC_OVF_BIT        7
`define ADC_RESULT_RESET   8'h00
`define ADC_SAMPLE_NS      12
`define ADC_CLK_NS         10
`define ADC_SAMPLE_CYCLES  ((`ADC_SAMPLE_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)
`define ADC_SLOW_RATE_KHZ  100

`endif

// ===== hw/thermo_encoder.v
// thermometer to binary encoder with registered result
`timescale 1ns/1ns
module thermo_encoder #(
  parameter LEVELS = 128,
  parameter BITS   = 7
) (
  // clock
  input  wire              clk_sys,
  // control
  input  wire              load,
  input  wire [LEVELS-1:0] thermo,
  // result
  output reg  [BITS:0]     code_reg
);
  reg [BITS:0] count;
  integer      i;

  // count set comparators; a bubble costs one code, not a wild jump
  always @* begin
    count = {(BITS+1){1'b0}};
    for (i = 0; i < LEVELS; i = i + 1) begin
      count = count + {{BITS{1'b0}}, thermo[i]};
    end
  end

  // registered read data, updated while the latches are loaded
  always @(posedge clk_sys) begin
    if (load) begin
      code_reg <= count;
    end
  end
endmodule

// ===== testbench/flash_adc_monitor.sv
// assertions on the converter pipeline ports
`timescale 1ns/1ns
module flash_adc_monitor (
  // block inputs
  input logic         clk_sys,
  input logic         srst,
  input logic         conv_clk,
  input logic [127:0] comparators,
  input logic         data_select_active_low,
  input logic         output_select_active_high,
  // block outputs
  input logic [6:0]   data_out,
  input logic [6:0]   data_oe,
  input logic         overflow_out,
  input logic         overflow_oe,
  input logic         result_strobe
);
  // up_reg keeps the enable check off pin history from inside reset
  reg  [2:0] up_reg;
  wire [7:0] code_w = &comparators ? 8'hFF : 8'($countones(comparators));
  wire       sel_w = ~data_select_active_low & output_select_active_high;
  always @(posedge clk_sys) up_reg <= srst ? 3'h0 : {up_reg[1:0], 1'b1};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence rise_s; !conv_clk ##1 conv_clk; endsequence
  a_rise_strobe: assert property (rise_s |-> ##3 result_strobe)
    else $error("strobe late");
  a_strobe_cause: assert property (result_strobe |-> $past(conv_clk, 3)
    && !$past(conv_clk, 4)) else $error("strobe without rise");
  a_strobe_pulse: assert property (result_strobe |=> !result_strobe)
    else $error("strobe too long");
  a_data_holds: assert property (!result_strobe |=> $stable({overflow_out, data_out}))
    else $error("result moved");
  a_code_value: assert property (result_strobe |=>
    {overflow_out, data_out} == $past(code_w, 2)) else $error("code wrong");
  a_ovf_ones: assert property (overflow_out |-> data_out == 7'h7F)
    else $error("overflow data");
  a_enable_map: assert property (up_reg[2] |-> {overflow_oe, data_oe} ==
    {$past(output_select_active_high, 3), {7{$past(sel_w, 3)}}}) else $error("enables wrong");
endmodule

// ===== testbench/conv_source.sv
// converter clock source of the capture side
`timescale 1ns/1ns
module conv_source (
  // system clock
  input  wire clk_sys,
  // converter clock pin
  output reg  conv_clk = 1'b0
);
  // hold a level n cycles; high, low, high yields one result
  task drive(input v, input integer n);
    begin
      conv_clk = v;
      repeat (n) @(negedge clk_sys);
    end
  endtask
endmodule

// ===== testbench/flash_adc_pipeline_test.sv
// self-checking bench for the converter pipeline
`timescale 1ns/1ns
module flash_adc_pipeline_test;
  reg          clk_sys = 1'b0;
  reg          srst = 1'b1;
  reg          data_select_active_low = 1'b0;
  reg          output_select_active_high = 1'b1;
  reg  [127:0] comparators = 128'h0;
  wire         conv_clk, overflow_out, overflow_oe, result_strobe;
  wire [6:0]   data_out, data_oe;
  integer      failures = 0, n_tests = 0, i;
  integer      levels[9] = '{0, 1, 32, 63, 64, 65, 96, 127, 128};
  flash_adc_pipeline dut_u (.clk_sys, .srst, .conv_clk, .comparators, .data_select_active_low,
    .output_select_active_high, .data_out, .data_oe, .overflow_out, .overflow_oe, .result_strobe);
  conv_source src_u (.clk_sys, .conv_clk);
  // free-running system clock
  initial forever #5 clk_sys = ~clk_sys;
  task check(input string what, input [7:0] exp, got);
    begin
      n_tests++;
      if (got !== exp) begin
        failures++;
        $display("wrong value %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // sample n set comparators, return to auto-zero, read the code
  task convert(input integer n, lo);
    begin
      comparators = ~({128{1'b1}} << n);
      src_u.drive(0, lo);
      src_u.drive(1, 5);
      check("code", (n == 128) ? 8'hFF : n[7:0], {overflow_out, data_out});
    end
  endtask
  task t_select;
    for (i = 0; i < 4; i++) begin
      {data_select_active_low, output_select_active_high} = i[1:0];
      repeat (4) @(negedge clk_sys);
      check("enables", {i[0], {7{~i[1] & i[0]}}}, {overflow_oe, data_oe});
    end
  endtask
  task t_codes;
    begin
      src_u.drive(1, 4);
      foreach (levels[k]) convert(levels[k], 3);
      convert(64, 40);
      for (i = 0; i < 3; i++) convert(65 + 2 * i, 3);
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // reset, scenarios, verdict
  initial begin
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    repeat (3) @(negedge clk_sys);
    t_select();
    t_codes();
    report_and_stop();
  end
  // watchdog well past the roughly 170 cycles of tests
  initial begin
    #50000;
    failures++;
    report_and_stop();
  end
endmodule
bind flash_adc_pipeline flash_adc_monitor mon_u (.clk_sys, .srst, .conv_clk, .comparators,
  .data_select_active_low, .output_select_active_high, .data_out, .data_oe, .overflow_out,
  .overflow_oe, .result_strobe);
